// ---- pms_sequencer.sv ----
// Power sequencer top: power-up order, turn-off events, APB registers
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module pms_sequencer
#(
	parameter int REG_RAMP_CYCLES = pms_pkg::REG_RAMP_CYC,
	parameter int PGOOD_CYCLES = pms_pkg::PGOOD_CYC,
	parameter int BUTTON_CYCLES = pms_pkg::BUTTON_CYC
)
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power events
	input wire logic turn_on_event,
	input wire logic supply_undervolt_falling,
	input wire logic power_button_in,
	input wire logic thermal_shutdown_in,
	input wire logic thermal_trip_n_in,
	input wire logic battery_overcurrent_det,
	// Sequenced rails
	input wire logic [3:0] rail_ok,
	output logic [3:0] rail_en,
	output logic internal_reg_en,
	output logic power_good_out,
	output logic reset_n_out,
	output logic host_interrupt_out,
	// Core voltage code
	input wire logic [6:0] volt_code_bus,
	input wire logic [1:0] volt_code_latch_en,
	output pms_pkg::pms_vid_out_s cpu_dac,
	output pms_pkg::pms_vid_out_s gfx_dac,
	// Core bucks
	input wire logic cpu_oc_det,
	input wire logic gfx_oc_det,
	input wire logic cpu_load_light,
	input wire logic gfx_load_light,
	input wire logic [9:0] cpu_current_adc,
	input wire logic [9:0] gfx_current_adc,
	output pms_pkg::pms_buck_out_s cpu_buck,
	output pms_pkg::pms_buck_out_s gfx_buck,
	output logic cpu_core_fault,
	output logic regulator_fault_irq,
	// Boost
	output logic boost_on,
	output logic [7:0] boost_level
);
	import pms_pkg::*;

	typedef enum {ST_OFF, ST_REG_RAMP, ST_STEP_DLY, ST_RAIL_RAMP, ST_PG_WAIT, ST_RST_WAIT,
		ST_INT_WAIT, ST_ACTIVE, ST_SYS_OFF, ST_UV_OFF} pms_seq_e;

	pms_seq_e state;
	logic [31:0] timer;
	logic [31:0] btn_cnt;
	logic [1:0] rail_idx;
	logic turn_off;
	logic btn_long;
	logic enter_active;
	logic int_pending;

	logic [7:0] mode_reg [2];
	logic [7:0] latch_reg [2];
	logic [8:0] boost_reg;
	logic [9:0] cur_reg [2];
	logic [1:0] key_stage;
	logic test_mode;

	logic setup;
	logic wr;
	logic addr_ok;
	logic [31:0] rd_val;
	pms_buck_out_s buck_q [2];
	pms_vid_out_s vid_q [2];

	// Turn-off events
	always_comb
	begin
		turn_off = btn_long || thermal_shutdown_in || !thermal_trip_n_in
			|| battery_overcurrent_det;
		enter_active = clk_en && (state == ST_INT_WAIT) && (timer == 32'(INT_CYC - 1));
	end

	// Power button hold counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			btn_cnt <= '0;
			btn_long <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!power_button_in)
			begin
				btn_cnt <= '0;
				btn_long <= 1'b0;
			end
			else if (btn_cnt >= 32'(BUTTON_CYCLES))
				btn_long <= 1'b1;
			else
				btn_cnt <= btn_cnt + 32'h1;
		end
	end

	// Power sequence state machine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_OFF;
			timer <= '0;
			rail_idx <= '0;
			rail_en <= '0;
			internal_reg_en <= 1'b0;
			power_good_out <= 1'b0;
			reset_n_out <= 1'b0;
		end
		else if (clk_en)
		begin
			timer <= timer + 32'h1;
			if (supply_undervolt_falling)
			begin
				state <= ST_UV_OFF;
				rail_en <= '0;
				internal_reg_en <= 1'b0;
				power_good_out <= 1'b0;
				reset_n_out <= 1'b0;
			end
			else if (turn_off && state != ST_OFF && state != ST_SYS_OFF && state != ST_UV_OFF)
			begin
				state <= ST_SYS_OFF;
				rail_en <= '0;
				power_good_out <= 1'b0;
				reset_n_out <= 1'b0;
			end
			else
			begin
				case (state)
					ST_OFF, ST_SYS_OFF, ST_UV_OFF:
					begin
						if (turn_on_event)
						begin
							state <= ST_REG_RAMP;
							internal_reg_en <= 1'b1;
							rail_idx <= '0;
							timer <= '0;
						end
					end
					ST_REG_RAMP:
					begin
						if (timer == 32'(REG_RAMP_CYCLES - 1))
						begin
							state <= ST_STEP_DLY;
							timer <= '0;
						end
					end
					ST_STEP_DLY:
					begin
						if (timer == 32'(STEP_CYC - 1))
						begin
							rail_en[rail_idx] <= 1'b1;
							state <= ST_RAIL_RAMP;
						end
					end
					ST_RAIL_RAMP:
					begin
						timer <= '0;
						if (rail_ok[rail_idx])
						begin
							rail_idx <= rail_idx + 2'h1;
							state <= (rail_idx == 2'(NRAIL - 1)) ? ST_PG_WAIT : ST_STEP_DLY;
						end
					end
					ST_PG_WAIT:
					begin
						if (timer == 32'(PGOOD_CYCLES - 1))
						begin
							power_good_out <= 1'b1;
							state <= ST_RST_WAIT;
							timer <= '0;
						end
					end
					ST_RST_WAIT:
					begin
						if (timer == 32'(RST_CYC - 1))
						begin
							reset_n_out <= 1'b1;
							state <= ST_INT_WAIT;
							timer <= '0;
						end
					end
					ST_INT_WAIT:
					begin
						if (timer == 32'(INT_CYC - 1))
							state <= ST_ACTIVE;
					end
					ST_ACTIVE:
					begin
						timer <= '0;
					end
					default:
					begin
						state <= ST_OFF;
					end
				endcase
			end
		end
	end

	// APB strobes
	always_comb
	begin
		setup = psel && !penable;
		wr = psel && penable && pready && pwrite && addr_ok;
	end

	// Host interrupt flag; set wins over a clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_pending <= 1'b0;
			host_interrupt_out <= 1'b0;
		end
		else if (clk_en)
		begin
			if (enter_active)
				int_pending <= 1'b1;
			else if (wr && paddr == OFS_STATUS && pwdata[STAT_INT_BIT])
				int_pending <= 1'b0;
			host_interrupt_out <= int_pending || enter_active;
		end
	end

	// Mode, latch and boost registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_reg[0] <= CPU_MODE_RST;
			mode_reg[1] <= GFX_MODE_RST;
			latch_reg[0] <= LATCH_RST;
			latch_reg[1] <= LATCH_RST;
			boost_reg <= BOOST_RST;
		end
		else if (clk_en && wr)
		begin
			case (paddr)
				OFS_CPU_MODE: mode_reg[0] <= pwdata[7:0];
				OFS_GFX_MODE: mode_reg[1] <= pwdata[7:0];
				OFS_CPU_LATCH: latch_reg[0] <= pwdata[7:0];
				OFS_GFX_LATCH: latch_reg[1] <= pwdata[7:0];
				OFS_BOOST: boost_reg <= pwdata[8:0];
				default: ;
			endcase
		end
	end

	// Keyed test entry: three exact writes in a row
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			key_stage <= '0;
			test_mode <= 1'b0;
		end
		else if (clk_en && wr && paddr == OFS_TEST)
		begin
			if (key_stage == 2'h0 && pwdata == TEST_KEY1)
				key_stage <= 2'h1;
			else if (key_stage == 2'h1 && pwdata == TEST_KEY2)
				key_stage <= 2'h2;
			else if (key_stage == 2'h2 && pwdata == TEST_ENTER)
			begin
				key_stage <= 2'h0;
				test_mode <= 1'b1;
			end
			else
			begin
				key_stage <= 2'h0;
				test_mode <= 1'b0;
			end
		end
	end

	// Current samples and boost outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur_reg[0] <= '0;
			cur_reg[1] <= '0;
			boost_on <= 1'b0;
			boost_level <= '0;
			cpu_core_fault <= 1'b0;
			regulator_fault_irq <= 1'b0;
		end
		else if (clk_en)
		begin
			cur_reg[0] <= cpu_current_adc;
			cur_reg[1] <= gfx_current_adc;
			boost_on <= boost_reg[BOOST_ON_BIT] || test_mode;
			boost_level <= boost_reg[7:0];
			cpu_core_fault <= buck_q[0].fault;
			regulator_fault_irq <= buck_q[0].fault || buck_q[1].fault;
		end
	end

	// Read mux; captured voltage codes stay out of it
	always_comb
	begin
		addr_ok = 1'b1;
		rd_val = '0;
		case (paddr)
			OFS_CPU_MODE: rd_val = {24'h0, mode_reg[0]};
			OFS_GFX_MODE: rd_val = {24'h0, mode_reg[1]};
			OFS_CPU_LATCH: rd_val = {24'h0, latch_reg[0]};
			OFS_GFX_LATCH: rd_val = {24'h0, latch_reg[1]};
			OFS_BOOST: rd_val = {23'h0, boost_reg};
			OFS_STATUS: rd_val = {18'h0, regulator_fault_irq, cpu_core_fault, test_mode,
				int_pending, reset_n_out, power_good_out, rail_en, 4'(state)};
			OFS_CPU_CUR: rd_val = {22'h0, cur_reg[0]};
			OFS_GFX_CUR: rd_val = {22'h0, cur_reg[1]};
			OFS_TEST: rd_val = {31'h0, test_mode};
			default: addr_ok = 1'b0;
		endcase
	end

	// APB answer: one wait-free access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready <= setup;
			pslverr <= setup && !addr_ok;
			if (setup)
				prdata <= pwrite ? 32'h0 : rd_val;
		end
	end

	// Per-core buck and voltage code logic
	for (genvar i = 0; i < 2; i++)
	begin : g_core
		pms_buck_ctrl u_buck
		(
			.pclk(pclk),
			.presetn(presetn),
			.clk_en(clk_en),
			.mode(mode_reg[i][MODE_LSB +: MODE_W]),
			.test_mode(test_mode),
			.oc_det(i == 0 ? cpu_oc_det : gfx_oc_det),
			.load_light(i == 0 ? cpu_load_light : gfx_load_light),
			.ctrl(buck_q[i])
		);
		pms_vid_latch u_vid
		(
			.pclk(pclk),
			.presetn(presetn),
			.clk_en(clk_en),
			.volt_code_bus(volt_code_bus),
			.volt_code_latch_en(volt_code_latch_en),
			.sel_code(i == 0 ? LE_CPU : LE_GFX),
			.volt_code_override(latch_reg[i][OVR_BIT]),
			.sw_code(latch_reg[i][6:0]),
			.dac(vid_q[i])
		);
	end

	// Submodule flops drive the ports directly
	assign cpu_buck = buck_q[0];
	assign gfx_buck = buck_q[1];
	assign cpu_dac = vid_q[0];
	assign gfx_dac = vid_q[1];

endmodule

// ---- pms_pkg.sv ----
// Shared constants, types and decode helpers for the power sequencer block
package pms_pkg;

	// Clock rate
	localparam int CLK_MHZ = 50;

	// Power-up timing, printed units then cycles
	localparam int T_REG_RAMP_US = 100;
	localparam int REG_RAMP_CYC = T_REG_RAMP_US * CLK_MHZ;
	localparam int T_STEP_US = 1;
	localparam int STEP_CYC = T_STEP_US * CLK_MHZ;
	localparam int T_PGOOD_MS = 80;
	localparam int PGOOD_CYC = T_PGOOD_MS * 1000 * CLK_MHZ;
	localparam int T_RST_NS = 2000;
	localparam int RST_CYC = (T_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int T_INT_US = 64;
	localparam int INT_CYC = T_INT_US * CLK_MHZ;
	localparam int T_BUTTON_S = 5;
	localparam int BUTTON_CYC = T_BUTTON_S * 1000000 * CLK_MHZ;

	// Voltage code: 0.3 V to 1.2 V in 12.5 mV steps, slewing 25 mV/us
	localparam int VID_MIN_MV = 300;
	localparam int VID_MAX_MV = 1200;
	localparam int VID_STEP_UV = 12500;
	localparam int SLEW_UV_PER_US = 25000;
	localparam int VID_MAX_CODE = (VID_MAX_MV - VID_MIN_MV) * 1000 / VID_STEP_UV;
	localparam int SLEW_CYC = VID_STEP_UV * CLK_MHZ / SLEW_UV_PER_US;
	localparam int VID_W = 7;

	// Sequenced rails, in power-up order
	localparam int NRAIL = 4;
	localparam int RAIL_1P5 = 0;
	localparam int RAIL_AON = 1;
	localparam int RAIL_2P1 = 2;
	localparam int RAIL_DEV = 3;

	// Register byte offsets
	localparam logic [7:0] OFS_CPU_MODE = 8'h00;
	localparam logic [7:0] OFS_GFX_MODE = 8'h04;
	localparam logic [7:0] OFS_CPU_LATCH = 8'h08;
	localparam logic [7:0] OFS_GFX_LATCH = 8'h0C;
	localparam logic [7:0] OFS_BOOST = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_CPU_CUR = 8'h18;
	localparam logic [7:0] OFS_GFX_CUR = 8'h1C;
	localparam logic [7:0] OFS_TEST = 8'h20;

	// Register reset values and fields
	localparam logic [7:0] CPU_MODE_RST = 8'h24;
	localparam logic [7:0] GFX_MODE_RST = 8'h04;
	localparam logic [7:0] LATCH_RST = 8'h7F;
	localparam logic [8:0] BOOST_RST = 9'h000;
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 3;
	localparam int OVR_BIT = 7;
	localparam int BOOST_ON_BIT = 8;
	localparam int STAT_INT_BIT = 8;
	localparam int CUR_W = 10;

	// Test entry key sequence
	localparam logic [31:0] TEST_KEY1 = 32'h0000_00A5;
	localparam logic [31:0] TEST_KEY2 = 32'h0000_005A;
	localparam logic [31:0] TEST_ENTER = 32'h0000_00C3;

	// Buck mode codes
	localparam logic [2:0] MODE_OFF = 3'h4;
	localparam logic [2:0] MODE_PFM = 3'h5;
	localparam logic [2:0] MODE_AUTO = 3'h6;
	localparam logic [2:0] MODE_PWM = 3'h7;

	// Latch enable codes per core
	localparam logic [1:0] LE_CPU = 2'h1;
	localparam logic [1:0] LE_GFX = 2'h2;

	typedef enum {BM_OFF, BM_PFM, BM_AUTO, BM_PWM} pms_buck_mode_e;

	typedef struct packed {
		logic enable;
		logic discharge;
		logic pulse_freq_mode;
		logic pulse_skip;
		logic pwm;
		logic test;
		logic current_limit;
		logic fault;
	} pms_buck_out_s;

	localparam pms_buck_out_s BUCK_OUT_RST = 8'h40;

	typedef struct packed {
		logic [6:0] code;
		logic busy;
	} pms_vid_out_s;

	// Mode field decode; reserved codes act as off
	function automatic pms_buck_mode_e buck_decode(input logic [2:0] code);
		pms_buck_mode_e m;
		m = BM_OFF;
		case (code)
			MODE_PFM: m = BM_PFM;
			MODE_AUTO: m = BM_AUTO;
			MODE_PWM: m = BM_PWM;
			default: m = BM_OFF;
		endcase
		return m;
	endfunction

	// True when the latch-enable pair selects exactly this core
	function automatic logic vid_selected(input logic [1:0] le, input logic [1:0] code);
		return le == code;
	endfunction

endpackage

// ---- pms_buck_ctrl.sv ----
// Buck regulator operating-mode decode and over-current flagging
`timescale 1ns/100ps
module pms_buck_ctrl
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Control
	input wire logic [2:0] mode,
	input wire logic test_mode,
	// Analog status
	input wire logic oc_det,
	input wire logic load_light,
	// Regulator controls
	output pms_pkg::pms_buck_out_s ctrl
);
	import pms_pkg::*;

	pms_buck_mode_e m;
	logic on;

	// Mode decode
	always_comb
	begin
		m = buck_decode(mode);
		on = (m != BM_OFF) || test_mode;
	end

	// Registered regulator controls
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= BUCK_OUT_RST;
		end
		else if (clk_en)
		begin
			ctrl.enable <= on;
			ctrl.discharge <= !on;
			ctrl.pulse_freq_mode <= (m == BM_PFM) && !test_mode;
			ctrl.pulse_skip <= (m == BM_AUTO) && load_light && !test_mode;
			ctrl.pwm <= ((m == BM_PWM) || ((m == BM_AUTO) && !load_light)) && !test_mode;
			ctrl.test <= test_mode;
			ctrl.current_limit <= on && oc_det;
			ctrl.fault <= on && oc_det;
		end
	end

endmodule

// ---- pms_vid_latch.sv ----
// Voltage-code capture from the shared bus and slewed DAC code
`timescale 1ns/100ps
module pms_vid_latch
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Shared bus
	input wire logic [6:0] volt_code_bus,
	input wire logic [1:0] volt_code_latch_en,
	input wire logic [1:0] sel_code,
	// Software source
	input wire logic volt_code_override,
	input wire logic [6:0] sw_code,
	// DAC drive
	output pms_pkg::pms_vid_out_s dac
);
	import pms_pkg::*;

	logic [6:0] captured;
	logic [6:0] target;
	logic [6:0] next_target;
	logic [5:0] slew_cnt;

	// Capture only while this core alone is selected
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			captured <= LATCH_RST[6:0];
		else if (clk_en && vid_selected(volt_code_latch_en, sel_code))
			captured <= volt_code_bus;
	end

	// Source select and range clamp
	always_comb
	begin
		next_target = volt_code_override ? sw_code : captured;
		if (next_target > 7'(VID_MAX_CODE))
			next_target = 7'(VID_MAX_CODE);
	end

	// Target register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			target <= 7'(VID_MAX_CODE);
		else if (clk_en)
			target <= next_target;
	end

	// Step one code per slew interval toward target
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dac <= '0;
			slew_cnt <= '0;
		end
		else if (clk_en)
		begin
			dac.busy <= dac.code != target;
			if (dac.code == target)
				slew_cnt <= '0;
			else if (slew_cnt == 6'(SLEW_CYC - 1))
			begin
				slew_cnt <= '0;
				dac.code <= (dac.code < target) ? dac.code + 7'h01 : dac.code - 7'h01;
			end
			else
				slew_cnt <= slew_cnt + 6'h01;
		end
	end

endmodule

// ---- pms_sequencer_properties.sv ----
// Checker for the power sequencer top ports
`timescale 1ns/100ps
module pms_sequencer_properties
	import pms_pkg::*;
#(
	parameter int REG_RAMP_CYCLES = 20,
	parameter int PGOOD_CYCLES = 40,
	parameter int BUTTON_CYCLES = 30
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events
	input wire logic power_button_in,
	input wire logic thermal_shutdown_in,
	input wire logic thermal_trip_n_in,
	input wire logic battery_overcurrent_det,
	input wire logic supply_undervolt_falling,
	input wire logic cpu_oc_det,
	// Outputs watched
	input wire logic [3:0] rail_ok,
	input wire logic [3:0] rail_en,
	input wire logic internal_reg_en,
	input wire logic power_good_out,
	input wire logic reset_n_out,
	input wire logic host_interrupt_out,
	input wire logic cpu_core_fault,
	input wire logic regulator_fault_irq,
	input wire pms_vid_out_s cpu_dac
);
	int unsigned n_int;
	int unsigned n_btn;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Interrupt wait and button hold counters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			n_int <= 0;
			n_btn <= 0;
		end
		else
		begin
			n_int <= (reset_n_out && !host_interrupt_out) ? n_int + 1 : 0;
			n_btn <= power_button_in ? n_btn + 1 : 0;
		end
	end
	property p_ramp; $rose(rail_en[0]) |-> $past(internal_reg_en, REG_RAMP_CYCLES); endproperty
	a_ramp: assert property (p_ramp) else $error("rail before ramp");
	property p_step; $rose(rail_ok[0]) |-> ##[0:1000] (rail_en[1] || !rail_en[0]); endproperty
	a_step: assert property (p_step) else $error("rail step late");
	property p_pgood; $rose(power_good_out) |-> $past(rail_ok, PGOOD_CYCLES) == 4'hF; endproperty
	a_pgood: assert property (p_pgood) else $error("power good early");
	property p_rst; $rose(power_good_out) |-> ##49 !reset_n_out ##[1:1000] reset_n_out; endproperty
	a_rst: assert property (p_rst) else $error("reset release timing");
	property p_int; $rose(host_interrupt_out) |-> n_int >= 1549 && n_int <= 6200; endproperty
	a_int: assert property (p_int) else $error("interrupt timing");
	property p_btn; n_btn == BUTTON_CYCLES + 6 |-> rail_en == 4'h0 && !power_good_out; endproperty
	a_btn: assert property (p_btn) else $error("button not off");
	property p_therm;
		($rose(thermal_shutdown_in) || $fell(thermal_trip_n_in)) && internal_reg_en
			|-> ##[1:3] (rail_en == 4'h0 && !power_good_out && internal_reg_en);
	endproperty
	a_therm: assert property (p_therm) else $error("thermal not off");
	property p_batoc;
		$rose(battery_overcurrent_det) && internal_reg_en
			|-> ##[1:3] (rail_en == 4'h0 && !power_good_out && internal_reg_en);
	endproperty
	a_batoc: assert property (p_batoc) else $error("overcurrent not off");
	property p_uv; $rose(supply_undervolt_falling) |-> ##[1:3] !internal_reg_en; endproperty
	a_uv: assert property (p_uv) else $error("undervolt not off");
	property p_slew;
		$changed(cpu_dac.code) |-> (cpu_dac.code == $past(cpu_dac.code) + 7'h01
			|| cpu_dac.code + 7'h01 == $past(cpu_dac.code)) ##1 $stable(cpu_dac.code) [*8];
	endproperty
	a_slew: assert property (p_slew) else $error("code slew");
	property p_fault; $rose(cpu_oc_det) |-> ##2 (cpu_core_fault && regulator_fault_irq); endproperty
	a_fault: assert property (p_fault) else $error("fault late");
endmodule
bind pms_sequencer pms_sequencer_properties #(
	.REG_RAMP_CYCLES(REG_RAMP_CYCLES),
	.PGOOD_CYCLES(PGOOD_CYCLES),
	.BUTTON_CYCLES(BUTTON_CYCLES)
) pms_sequencer_properties_inst (.*);

// ---- pms_far_side.sv ----
// Far-side model: rail ramps and the shared voltage-code pins for both cores
`timescale 1ns/100ps
module pms_far_side
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Rails
	input wire logic [3:0] rail_en,
	output logic [3:0] rail_ok,
	// Voltage code pins
	output logic [6:0] volt_code_bus,
	output logic [1:0] volt_code_latch_en
);
	logic [3:0] ramp;
	// Rail reports up two cycles after its enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ramp <= 4'h0;
			rail_ok <= 4'h0;
		end
		else
		begin
			ramp <= rail_en;
			rail_ok <= ramp & rail_en;
		end
	end
	initial
	begin
		volt_code_bus = 7'h00;
		volt_code_latch_en = 2'h0;
	end
	// Code to one core; latch closed around it, bus scrambled after
	task load(input logic [1:0] le, input logic [6:0] code);
		volt_code_latch_en <= 2'h0;
		volt_code_bus <= code;
		@(posedge pclk);
		volt_code_latch_en <= le;
		@(posedge pclk);
		volt_code_latch_en <= 2'h0;
		@(posedge pclk);
		volt_code_bus <= ~code;
	endtask
endmodule

// ---- pms_sequencer_tb.sv ----
// Testbench for the power sequencer top
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
	$display("unexpected %s: expected %h seen %h", n, e, a); end end
module pms_sequencer_tb;
	import pms_pkg::*;
	localparam int BTN = 30;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr, boost_level;
	logic [31:0] pwdata, prdata, rd;
	logic turn_on_event, supply_undervolt_falling, power_button_in, thermal_shutdown_in;
	logic thermal_trip_n_in, battery_overcurrent_det, internal_reg_en, power_good_out;
	logic reset_n_out, host_interrupt_out, cpu_oc_det, gfx_oc_det, cpu_load_light;
	logic gfx_load_light, cpu_core_fault, regulator_fault_irq, boost_on;
	logic [3:0] rail_ok, rail_en;
	logic [6:0] volt_code_bus;
	logic [1:0] volt_code_latch_en;
	logic [9:0] cpu_current_adc, gfx_current_adc;
	pms_vid_out_s cpu_dac, gfx_dac;
	pms_buck_out_s cpu_buck, gfx_buck;
	int n_mismatch, checked;
	pms_sequencer #(.REG_RAMP_CYCLES(20), .PGOOD_CYCLES(40), .BUTTON_CYCLES(BTN))
		pms_sequencer_inst (.*);
	pms_far_side pms_far_side_inst (.*);
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task test_done();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer, idle cycle after
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Clear a stale interrupt, turn on and wait for the host interrupt
	task up();
		apb(1'b1, OFS_STATUS, 32'h100);
		turn_on_event <= 1'b1;
		cyc(1);
		turn_on_event <= 1'b0;
		for (int i = 0; i < 9000 && host_interrupt_out !== 1'b1; i++)
			@(posedge pclk);
		`CHK("int", 1'b1, host_interrupt_out)
		`CHK("rails", 4'hF, rail_en)
		`CHK("pgood", 1'b1, power_good_out)
		`CHK("rst", 1'b1, reset_n_out)
	endtask
	task t_up();
		up();
		apb(1'b1, OFS_STATUS, 32'h100);
		cyc(1);
		`CHK("int_clr", 1'b0, host_interrupt_out)
	endtask
	task t_off();
		for (int ev = 0; ev < 5; ev++)
		begin
			// First event hits the active state left by t_up
			if (ev > 0)
				up();
			case (ev)
				0: power_button_in <= 1'b1;
				1: thermal_shutdown_in <= 1'b1;
				2: thermal_trip_n_in <= 1'b0;
				3: battery_overcurrent_det <= 1'b1;
				default: supply_undervolt_falling <= 1'b1;
			endcase
			cyc(BTN - 4);
			if (ev == 0)
				`CHK("early", 1'b1, power_good_out)
			cyc(12);
			`CHK("off", 4'h0, rail_en)
			`CHK("ireg", ev < 4, internal_reg_en)
			{power_button_in, thermal_shutdown_in, battery_overcurrent_det} <= 3'h0;
			thermal_trip_n_in <= 1'b1;
			supply_undervolt_falling <= 1'b0;
			cyc(2);
		end
	endtask
	task t_restart();
		turn_on_event <= 1'b1;
		cyc(1);
		turn_on_event <= 1'b0;
		cyc(100);
		battery_overcurrent_det <= 1'b1;
		cyc(4);
		`CHK("abort", 4'h0, rail_en)
		battery_overcurrent_det <= 1'b0;
		up();
	endtask
	task t_modes();
		pms_buck_out_s exp;
		apb(1'b0, OFS_CPU_MODE, 32'h0);
		`CHK("mode_rst", {24'h0, CPU_MODE_RST}, rd)
		`CHK("gfx_off", 1'b1, gfx_buck.discharge)
		cpu_load_light <= 1'b1;
		for (int m = 0; m < 8; m++)
		begin
			apb(1'b1, OFS_CPU_MODE, 32'(m));
			cyc(1);
			exp = '0;
			exp.enable = m > 4;
			exp.discharge = m <= 4;
			exp.pulse_freq_mode = m == 5;
			exp.pulse_skip = m == 6;
			exp.pwm = m == 7;
			`CHK("buck", exp, cpu_buck)
		end
		cpu_load_light <= 1'b0;
		apb(1'b1, OFS_CPU_MODE, 32'h6);
		cyc(1);
		`CHK("auto_pwm", 1'b1, cpu_buck.pwm)
	endtask
	task t_fault();
		cpu_current_adc <= 10'h2C5;
		cpu_oc_det <= 1'b1;
		cyc(3);
		`CHK("fault", 2'h3, {cpu_core_fault, regulator_fault_irq})
		`CHK("limit", 1'b1, cpu_buck.current_limit)
		cpu_oc_det <= 1'b0;
		apb(1'b0, OFS_CPU_CUR, 32'h0);
		`CHK("current", 32'h2C5, rd)
		apb(1'b0, OFS_GFX_CUR, 32'h0);
		`CHK("gfx_current", 32'h155, rd)
	endtask
	task t_vid();
		pms_far_side_inst.load(LE_CPU, 7'h10);
		cyc(100);
		`CHK("busy", 1'b1, cpu_dac.busy)
		// Both codes sit at the clamped reset target before this
		cyc((VID_MAX_CODE - 16) * SLEW_CYC);
		`CHK("cpu_code", 7'h10, cpu_dac.code)
		`CHK("gfx_code", 7'(VID_MAX_CODE), gfx_dac.code)
		apb(1'b0, OFS_CPU_LATCH, 32'h0);
		`CHK("latch_rd", 32'h7F, rd)
		pms_far_side_inst.load(LE_CPU, 7'h7F);
		cyc((VID_MAX_CODE - 16) * SLEW_CYC + 30);
		`CHK("clamp", 7'(VID_MAX_CODE), cpu_dac.code)
		pms_far_side_inst.load(LE_GFX, 7'h40);
		cyc((VID_MAX_CODE - 64) * SLEW_CYC + 30);
		`CHK("gfx_code2", 7'h40, gfx_dac.code)
		`CHK("cpu_keep", 7'(VID_MAX_CODE), cpu_dac.code)
		apb(1'b1, OFS_CPU_LATCH, 32'h85);
		// Slewing must stop while the clock enable is low
		clk_en <= 1'b0;
		cyc(60);
		`CHK("frozen", 7'(VID_MAX_CODE), cpu_dac.code)
		clk_en <= 1'b1;
		cyc((VID_MAX_CODE - 5) * SLEW_CYC + 30);
		`CHK("override", 7'h05, cpu_dac.code)
	endtask
	task t_test();
		apb(1'b1, OFS_TEST, TEST_KEY1);
		apb(1'b1, OFS_TEST, TEST_ENTER);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("test_skip", 1'b0, rd[11])
		apb(1'b1, OFS_TEST, TEST_KEY1);
		apb(1'b1, OFS_TEST, TEST_KEY2);
		apb(1'b1, OFS_TEST, TEST_ENTER);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("test_on", 1'b1, rd[11])
		`CHK("buck_test", 1'b1, cpu_buck.test)
		apb(1'b1, OFS_TEST, 32'h0);
		apb(1'b1, OFS_BOOST, 32'h1A7);
		cyc(1);
		`CHK("boost", 9'h1A7, {boost_on, boost_level})
		apb(1'b0, 8'h30, 32'h0);
		`CHK("slverr", 1'b1, er)
	endtask
	initial
	begin
		#2000000;
		n_mismatch++;
		test_done();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, turn_on_event} = '0;
		{supply_undervolt_falling, power_button_in, thermal_shutdown_in} = '0;
		{battery_overcurrent_det, cpu_oc_det, gfx_oc_det} = '0;
		{cpu_load_light, gfx_load_light, cpu_current_adc} = '0;
		gfx_current_adc = 10'h155;
		thermal_trip_n_in = 1'b1;
		clk_en = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_up();
		t_off();
		t_restart();
		t_modes();
		t_fault();
		t_vid();
		t_test();
		test_done();
	end
endmodule
